// ==== verilog/dob_pkg.sv ====
package dob_pkg;
  // ****************************************************************
  // Cell map seen by the user processor (8-bit cells)
  // ****************************************************************
  localparam logic [7:0] ADDR_OUT_STATE = 8'h0A;
  localparam logic [7:0] ADDR_OUT_FETCH = 8'h0B;
  localparam logic [7:0] ADDR_DIAG_STATE = 8'h0C;
  localparam logic [7:0] ADDR_DIAG_SWAP = 8'h0D;
  localparam logic [7:0] ADDR_DIAG1_HEAD = 8'h20;
  localparam logic [7:0] ADDR_DIAG2_HEAD = 8'h21;
  localparam logic [7:0] ADDR_DIAG1_LEN = 8'h22;
  localparam logic [7:0] ADDR_DIAG2_LEN = 8'h23;
  localparam logic [1:0] WIN_SEL_U = 2'h2;
  localparam logic [1:0] WIN_SEL_N = 2'h3;
  localparam int OUT_DEPTH = 32;
  localparam logic [7:0] DIAG_MAX_INDEX = 8'hF3;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FETCH_CLEARED_BIT = 3;
  localparam int FETCH_NEW_BIT = 2;
  localparam int HEAD_EXT_BIT = 0;
  localparam int HEAD_STAT_BIT = 1;
  localparam int HEAD_OVF_BIT = 2;
  localparam int GC_SYNC_BIT = 5;
  localparam int GC_UNSYNC_BIT = 4;
  localparam int GC_CLEAR_BIT = 1;
  // ****************************************************************
  // Output buffer pointers and their reset placement
  // ****************************************************************
  localparam logic [1:0] PTR_NIL = 2'h0;
  localparam logic [1:0] RST_PTR_F = 2'h0;
  localparam logic [1:0] RST_PTR_U = 2'h2;
  localparam logic [1:0] RST_PTR_N = 2'h1;
  localparam logic [1:0] RST_PTR_D = 2'h3;
  typedef enum logic [1:0] {
    DIAG_NONE = 2'b00,
    DIAG_USER = 2'b01,
    DIAG_DEVICE = 2'b10,
    DIAG_SENDING = 2'b11
  } dob_diag_type;
  // ****************************************************************
  // Controller registers on AHB-Lite and its orders
  // ****************************************************************
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_DIAG = 8'h08;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_IDLE = 2'b00;
  typedef enum logic [3:0] {
    OP_CELL_RD = 4'h0,
    OP_CELL_WR = 4'h1,
    OP_OUT_BYTE = 4'h2,
    OP_FRAME_OK = 4'h3,
    OP_GC = 4'h4,
    OP_LEAVE = 4'h5,
    OP_WAIT_PRM = 4'h6,
    OP_DIAG_START = 4'h7,
    OP_DIAG_DONE = 4'h8
  } dob_op_type;
  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_WAIT = 1'b1
  } dob_hst_type;
endpackage : dob_pkg

// ==== verilog/dob_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface dob_if;
  // User cell port
  logic cell_rd;
  logic cell_wr;
  logic [7:0] cell_addr;
  logic [7:0] cell_wdata;
  logic [7:0] cell_rdata;
  logic cell_ack;
  // Fieldbus events from the master
  logic out_we;
  logic [7:0] out_idx;
  logic [7:0] out_byte;
  logic frame_ok;
  logic gc_valid;
  logic [7:0] gc_cmd;
  logic leave_master;
  logic wait_prm;
  logic diag_start;
  logic diag_done;
  // Device indications
  logic output_received_interrupt;
  logic diag_changed_interrupt;
  logic diag_pending;
  logic [7:0] diag_head;
  logic [7:0] diag_len;
  modport device (
    input cell_rd, cell_wr, cell_addr, cell_wdata, out_we, out_idx, out_byte,
    input frame_ok, gc_valid, gc_cmd, leave_master, wait_prm, diag_start, diag_done,
    output cell_rdata, cell_ack, output_received_interrupt, diag_changed_interrupt,
    output diag_pending, diag_head, diag_len
  );
  modport party (
    output cell_rd, cell_wr, cell_addr, cell_wdata, out_we, out_idx, out_byte,
    output frame_ok, gc_valid, gc_cmd, leave_master, wait_prm, diag_start, diag_done,
    input cell_rdata, cell_ack, output_received_interrupt, diag_changed_interrupt,
    input diag_pending, diag_head, diag_len
  );
endinterface : dob_if
`default_nettype wire

// ==== verilog/dob_device.sv ====
// Local design decision: the dob_if link port; the AHB-Lite slave port sits in dob_party.
`timescale 1ns/100ps
`default_nettype none
module dob_device import dob_pkg::*; #(
  parameter int DEPTH = OUT_DEPTH
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // Link to master and user processor
  dob_if.device LINK,
  // Status
  output logic O_SYNC_ACTIVE
);
  localparam int IW = $clog2(DEPTH);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic fetch_rd;
  logic swap_rd;
  logic wr_u;
  logic wr_n;
  logic [IW-1:0] cell_idx;
  logic [IW-1:0] link_idx;
  assign fetch_rd = LINK.cell_rd && (LINK.cell_addr == ADDR_OUT_FETCH);
  assign swap_rd = LINK.cell_rd && (LINK.cell_addr == ADDR_DIAG_SWAP);
  assign wr_u = LINK.cell_wr && (LINK.cell_addr[7:6] == WIN_SEL_U);
  assign wr_n = LINK.cell_wr && (LINK.cell_addr[7:6] == WIN_SEL_N);
  assign cell_idx = LINK.cell_addr[IW-1:0];
  assign link_idx = LINK.out_idx[IW-1:0];

  // ****************************************************************
  // Output buffer rotation
  // ****************************************************************
  logic [1:0] ptr_f_q, ptr_u_q, ptr_n_q, ptr_d_q;
  logic [1:0] ptr_f_d, ptr_u_d, ptr_n_d, ptr_d_d;
  logic sync_q;
  logic sync_d;
  logic clear_d;
  logic move_d;
  logic fetched;
  logic [1:0] tmp;
  logic [3:1] clr_q;

  always_comb begin
    clear_d = LINK.leave_master || LINK.wait_prm ||
              (LINK.gc_valid && LINK.gc_cmd[GC_CLEAR_BIT]);
    sync_d = sync_q;
    move_d = clear_d;
    if (LINK.frame_ok && !sync_q) begin
      move_d = 1'b1;
    end
    if (LINK.gc_valid && (LINK.gc_cmd[GC_SYNC_BIT] || LINK.gc_cmd[GC_UNSYNC_BIT])) begin
      move_d = 1'b1;
      sync_d = LINK.gc_cmd[GC_SYNC_BIT];
    end
    ptr_f_d = ptr_f_q;
    ptr_u_d = ptr_u_q;
    ptr_n_d = ptr_n_q;
    ptr_d_d = ptr_d_q;
    fetched = 1'b0;
    tmp = PTR_NIL;
    if (fetch_rd && (ptr_n_q != PTR_NIL)) begin
      fetched = 1'b1;
      ptr_f_d = ptr_u_q;
      ptr_u_d = ptr_n_q;
      ptr_n_d = PTR_NIL;
    end
    if (move_d) begin
      if (ptr_n_d != PTR_NIL) begin
        tmp = ptr_n_d;
        ptr_n_d = ptr_d_d;
        ptr_d_d = tmp;
      end else begin
        ptr_n_d = ptr_d_d;
        ptr_d_d = ptr_f_d;
        ptr_f_d = PTR_NIL;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ptr_f_q <= RST_PTR_F;
      ptr_u_q <= RST_PTR_U;
      ptr_n_q <= RST_PTR_N;
      ptr_d_q <= RST_PTR_D;
      sync_q <= 1'b0;
      O_SYNC_ACTIVE <= 1'b0;
      LINK.output_received_interrupt <= 1'b0;
    end else begin
      ptr_f_q <= ptr_f_d;
      ptr_u_q <= ptr_u_d;
      ptr_n_q <= ptr_n_d;
      ptr_d_q <= ptr_d_d;
      sync_q <= sync_d;
      O_SYNC_ACTIVE <= sync_d;
      LINK.output_received_interrupt <= LINK.frame_ok && !sync_q;
    end
  end

  // ****************************************************************
  // Output buffer memory, one process per entry
  // ****************************************************************
  logic [7:0] mem_q [1:3][DEPTH];
  for (genvar b = 1; b <= 3; b++) begin : g_buf
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        clr_q[b] <= 1'b1;
      end else if (clear_d && ptr_d_q == 2'(b)) begin
        clr_q[b] <= 1'b1;
      end else if (LINK.out_we && ptr_d_q == 2'(b)) begin
        clr_q[b] <= 1'b0;
      end
    end
    for (genvar e = 0; e < DEPTH; e++) begin : g_ent
      always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          mem_q[b][e] <= 8'h00;
        end else if (clear_d && ptr_d_q == 2'(b)) begin
          mem_q[b][e] <= 8'h00;
        end else if (LINK.out_we && ptr_d_q == 2'(b) && link_idx == IW'(e)) begin
          mem_q[b][e] <= LINK.out_byte;
        end else if (wr_u && ptr_u_q == 2'(b) && cell_idx == IW'(e)) begin
          mem_q[b][e] <= LINK.cell_wdata;
        end else if (wr_n && ptr_n_q == 2'(b) && cell_idx == IW'(e)) begin
          mem_q[b][e] <= LINK.cell_wdata;
        end
      end
    end
  end

  // ****************************************************************
  // Diagnosis buffers
  // ****************************************************************
  dob_diag_type st_q [2];
  dob_diag_type st_d [2];
  logic [7:0] head_q [2];
  logic [7:0] len_q [2];
  logic [1:0] swap_ret;
  logic diag_chg;
  logic pend_clr;
  logic pend_q;
  logic [0:0] dev_sel;

  always_comb begin
    st_d = st_q;
    swap_ret = 2'h0;
    diag_chg = 1'b0;
    pend_clr = 1'b0;
    dev_sel = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (swap_rd && st_q[i] == DIAG_USER && !diag_chg) begin
        diag_chg = 1'b1;
        st_d[i] = DIAG_DEVICE;
        if (st_q[1-i] == DIAG_DEVICE) begin
          st_d[1-i] = DIAG_USER;
          swap_ret = 2'(2 - i);
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (LINK.diag_done && st_q[i] == DIAG_SENDING) begin
        st_d[i] = (st_d[1-i] == DIAG_DEVICE) ? DIAG_USER : DIAG_DEVICE;
        pend_clr = !head_q[i][HEAD_STAT_BIT];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (st_d[i] == DIAG_SENDING || st_d[i] == DIAG_DEVICE) begin
        dev_sel = 1'(i);
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (LINK.diag_start && st_d[i] == DIAG_DEVICE) begin
        st_d[i] = DIAG_SENDING;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_q[0] <= DIAG_USER;
      st_q[1] <= DIAG_DEVICE;
      pend_q <= 1'b0;
      LINK.diag_changed_interrupt <= 1'b0;
      LINK.diag_pending <= 1'b0;
      LINK.diag_head <= 8'h00;
      LINK.diag_len <= 8'h00;
    end else begin
      st_q <= st_d;
      if (diag_chg) begin
        pend_q <= 1'b1;
      end else if (pend_clr) begin
        pend_q <= 1'b0;
      end
      LINK.diag_changed_interrupt <= diag_chg;
      LINK.diag_pending <= diag_chg || (pend_q && !pend_clr);
      LINK.diag_head <= head_q[dev_sel];
      LINK.diag_len <= len_q[dev_sel];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      head_q[0] <= 8'h00;
      head_q[1] <= 8'h00;
      len_q[0] <= 8'h00;
      len_q[1] <= 8'h00;
    end else if (LINK.cell_wr) begin
      unique case (LINK.cell_addr)
        ADDR_DIAG1_HEAD: head_q[0] <= LINK.cell_wdata;
        ADDR_DIAG2_HEAD: head_q[1] <= LINK.cell_wdata;
        ADDR_DIAG1_LEN: len_q[0] <= (LINK.cell_wdata > DIAG_MAX_INDEX) ?
                                    DIAG_MAX_INDEX : LINK.cell_wdata;
        ADDR_DIAG2_LEN: len_q[1] <= (LINK.cell_wdata > DIAG_MAX_INDEX) ?
                                    DIAG_MAX_INDEX : LINK.cell_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Cell read answer, one cycle after the request
  // ****************************************************************
  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    if (LINK.cell_addr == ADDR_OUT_STATE) begin
      rdata_d = {ptr_f_q, ptr_u_q, ptr_n_q, ptr_d_q};
    end else if (LINK.cell_addr == ADDR_OUT_FETCH) begin
      rdata_d = {4'h0, clr_q[ptr_u_d], fetched, ptr_u_d};
      rdata_d[FETCH_CLEARED_BIT] = (ptr_u_d != PTR_NIL) && clr_q[ptr_u_d];
    end else if (LINK.cell_addr == ADDR_DIAG_STATE) begin
      rdata_d = {4'h0, st_q[1], st_q[0]};
    end else if (LINK.cell_addr == ADDR_DIAG_SWAP) begin
      rdata_d = {6'h00, swap_ret};
    end else if (LINK.cell_addr == ADDR_DIAG1_HEAD) begin
      rdata_d = head_q[0];
    end else if (LINK.cell_addr == ADDR_DIAG2_HEAD) begin
      rdata_d = head_q[1];
    end else if (LINK.cell_addr == ADDR_DIAG1_LEN) begin
      rdata_d = len_q[0];
    end else if (LINK.cell_addr == ADDR_DIAG2_LEN) begin
      rdata_d = len_q[1];
    end else if (LINK.cell_addr[7:6] == WIN_SEL_U && ptr_u_q != PTR_NIL) begin
      rdata_d = mem_q[ptr_u_q][cell_idx];
    end else if (LINK.cell_addr[7:6] == WIN_SEL_N && ptr_n_q != PTR_NIL) begin
      rdata_d = mem_q[ptr_n_q][cell_idx];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      LINK.cell_rdata <= 8'h00;
      LINK.cell_ack <= 1'b0;
    end else begin
      LINK.cell_rdata <= LINK.cell_rd ? rdata_d : 8'h00;
      LINK.cell_ack <= LINK.cell_rd || LINK.cell_wr;
    end
  end
endmodule : dob_device
`default_nettype wire

// ==== verilog/dob_party.sv ====
`timescale 1ns/100ps
`default_nettype none
module dob_party import dob_pkg::*; (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  // Link to the device
  dob_if.party LINK
);
  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // ****************************************************************
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  dob_hst_type state_q;
  logic [7:0] result_q;
  logic launch;
  dob_op_type op;
  assign op = dob_op_type'(I_HWDATA[3:0]);
  assign launch = wr_pend_q && (wr_addr_q == HOST_CTRL) && (state_q == HS_IDLE);

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      O_HRDATA <= 32'h00000000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      wr_pend_q <= I_HSEL && I_HREADY && I_HWRITE && I_HTRANS == HTRANS_NONSEQ;
      wr_addr_q <= I_HADDR[7:0];
      O_HRDATA <= 32'h00000000;
      if (I_HSEL && I_HREADY && !I_HWRITE && I_HTRANS == HTRANS_NONSEQ) begin
        if (I_HADDR[7:0] == HOST_STATUS) begin
          O_HRDATA <= {16'h0000, result_q, 6'h00, LINK.diag_pending, state_q};
        end else if (I_HADDR[7:0] == HOST_DIAG) begin
          O_HRDATA <= {16'h0000, LINK.diag_len, LINK.diag_head};
        end
      end
    end
  end

  // ****************************************************************
  // Order sequencer driving the link
  // ****************************************************************
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= HS_IDLE;
      result_q <= 8'h00;
      LINK.cell_rd <= 1'b0;
      LINK.cell_wr <= 1'b0;
      LINK.cell_addr <= 8'h00;
      LINK.cell_wdata <= 8'h00;
      LINK.out_we <= 1'b0;
      LINK.out_idx <= 8'h00;
      LINK.out_byte <= 8'h00;
      LINK.frame_ok <= 1'b0;
      LINK.gc_valid <= 1'b0;
      LINK.gc_cmd <= 8'h00;
      LINK.leave_master <= 1'b0;
      LINK.wait_prm <= 1'b0;
      LINK.diag_start <= 1'b0;
      LINK.diag_done <= 1'b0;
    end else begin
      LINK.cell_rd <= launch && op == OP_CELL_RD;
      LINK.cell_wr <= launch && op == OP_CELL_WR;
      LINK.out_we <= launch && op == OP_OUT_BYTE;
      LINK.frame_ok <= launch && op == OP_FRAME_OK;
      LINK.gc_valid <= launch && op == OP_GC;
      LINK.leave_master <= launch && op == OP_LEAVE;
      LINK.wait_prm <= launch && op == OP_WAIT_PRM;
      LINK.diag_start <= launch && op == OP_DIAG_START;
      LINK.diag_done <= launch && op == OP_DIAG_DONE;
      if (launch) begin
        LINK.cell_addr <= I_HWDATA[15:8];
        LINK.out_idx <= I_HWDATA[15:8];
        LINK.cell_wdata <= I_HWDATA[23:16];
        LINK.out_byte <= I_HWDATA[23:16];
        LINK.gc_cmd <= I_HWDATA[23:16];
      end
      unique case (state_q)
        HS_IDLE: begin
          if (launch && (op == OP_CELL_RD || op == OP_CELL_WR)) begin
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (LINK.cell_ack) begin
            result_q <= LINK.cell_rdata;
            state_q <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : dob_party
`default_nettype wire

// ==== test/dob_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module dob_properties import dob_pkg::*; (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // Link signals
  input wire logic cell_rd,
  input wire logic cell_wr,
  input wire logic [7:0] cell_addr,
  input wire logic [7:0] cell_rdata,
  input wire logic cell_ack,
  input wire logic frame_ok,
  input wire logic gc_valid,
  input wire logic [7:0] gc_cmd,
  input wire logic diag_done,
  input wire logic output_received_interrupt,
  input wire logic diag_changed_interrupt,
  input wire logic diag_pending,
  input wire logic [7:0] diag_head,
  input wire logic [7:0] diag_len
);
  // ********
  // Sync mode shadow
  // ********
  logic sync_q;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sync_q <= 1'b0;
    end else if (gc_valid && gc_cmd[GC_SYNC_BIT]) begin
      sync_q <= 1'b1;
    end else if (gc_valid && gc_cmd[GC_UNSYNC_BIT]) begin
      sync_q <= 1'b0;
    end
  end
  sequence cell_req(a);
    cell_rd && cell_addr == a;
  endsequence
  sequence swap_req;
    cell_rd && cell_addr == ADDR_DIAG_SWAP;
  endsequence
  ack_follows_a: assert property ((cell_rd || cell_wr) |=> cell_ack)
    else $error("cell access not acknowledged");
  ack_cause_a: assert property (cell_ack |-> $past(cell_rd || cell_wr))
    else $error("cell ack without access");
  diag_state_a: assert property (cell_req(ADDR_DIAG_STATE) |=> cell_rdata[7:4] == 4'h0)
    else $error("diagnosis state upper bits set");
  fetch_code_a: assert property (cell_req(ADDR_OUT_FETCH) |=>
    cell_rdata[7:4] == 4'h0 && cell_rdata[1:0] != PTR_NIL)
    else $error("fetch result malformed");
  swap_code_a: assert property (swap_req |=> cell_rdata[7:2] == 6'h0 && cell_rdata[1:0] != 2'h3)
    else $error("swap result malformed");
  swap_irq_a: assert property (swap_req |-> ##[1:2] diag_changed_interrupt)
    else $error("swap not confirmed");
  swap_pend_a: assert property (swap_req |-> ##[1:2] diag_pending)
    else $error("pending not set by swap");
  rx_irq_a: assert property (frame_ok && !sync_q |=> output_received_interrupt)
    else $error("frame without interrupt");
  sync_hold_a: assert property (frame_ok && sync_q && !gc_valid |=> !output_received_interrupt)
    else $error("interrupt in sync mode");
  static_keep_a: assert property (diag_done && diag_pending && diag_head[HEAD_STAT_BIT] |=>
    diag_pending)
    else $error("static pending dropped");
  pend_clear_a: assert property (diag_done && !diag_head[HEAD_STAT_BIT] && !cell_rd |=>
    !diag_pending)
    else $error("pending not cleared");
  len_cap_a: assert property (diag_len <= DIAG_MAX_INDEX)
    else $error("diagnosis length too large");
endmodule : dob_properties
`default_nettype wire

// ==== test/tb_diag_and_output_buffer_manager.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_diag_and_output_buffer_manager import dob_pkg::*;;
  logic clk;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic hready;
  logic hresp;
  logic sync_act;
  logic rd_pend = 1'b0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] seed;
  logic [31:0] st;
  logic [7:0] fb[8];
  logic [7:0] expq[$];
  int errors = 0;
  int checks = 0;
  int irqs = 0;
  dob_if link();
  dob_device #(.DEPTH(8)) u_dob_device (.I_CLOCK(clk), .I_RESETN(rst_n), .LINK(link.device),
    .O_SYNC_ACTIVE(sync_act));
  dob_party u_dob_party (.I_CLOCK(clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata),
    .LINK(link.party));
  dob_properties u_dob_properties (.I_CLOCK(clk), .I_RESETN(rst_n), .cell_rd(link.cell_rd),
    .cell_wr(link.cell_wr), .cell_addr(link.cell_addr), .cell_rdata(link.cell_rdata),
    .cell_ack(link.cell_ack), .frame_ok(link.frame_ok), .gc_valid(link.gc_valid),
    .gc_cmd(link.gc_cmd), .diag_done(link.diag_done),
    .output_received_interrupt(link.output_received_interrupt),
    .diag_changed_interrupt(link.diag_changed_interrupt), .diag_pending(link.diag_pending),
    .diag_head(link.diag_head), .diag_len(link.diag_len));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********
  // Bus and compare tasks
  // ********
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= HTRANS_IDLE;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic op(input logic [3:0] o, input logic [7:0] a, input logic [7:0] d);
    int n;
    ahb(1'b1, HOST_CTRL, {8'h00, d, a, 4'h0, o}, st);
    repeat (2) @(posedge clk);
    n = 0;
    do begin
      ahb(1'b0, HOST_STATUS, 32'h00000000, st);
      n++;
    end while (st[0] !== 1'b0 && n < 20);
    chk_bit("busy", 1'b0, st[0]);
    chk_bit("response", 1'b0, hresp);
  endtask : op
  task automatic rd_cell(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    op(OP_CELL_RD, a, 8'h00);
  endtask : rd_cell
  task automatic send_frame();
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      fb[i] = seed[7:0];
      op(OP_OUT_BYTE, i[7:0], fb[i]);
    end
    op(OP_FRAME_OK, 8'h00, 8'h00);
  endtask : send_frame
  task automatic check_u();
    for (int i = 0; i < 8; i++) begin
      rd_cell(8'h80 + i[7:0], fb[i]);
    end
  endtask : check_u
  task automatic close_out();
    if (expq.size() != 0) begin
      errors++;
      $display("wrong value pending reads expected 0 seen %0d", expq.size());
    end
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    if (link.cell_ack === 1'b1 && rd_pend === 1'b1) begin
      if (expq.size() == 0) begin
        errors++;
        $display("wrong value cell read expected none seen %h", link.cell_rdata);
      end else begin
        chk("cell read", expq.pop_front(), link.cell_rdata);
      end
    end
    rd_pend <= (link.cell_rd === 1'b1);
    if (link.output_received_interrupt === 1'b1) begin
      irqs++;
    end
  end
  initial begin
    #200000;
    errors++;
    close_out();
  end
  // ********
  // Test sequence
  // ********
  initial begin
    logic [3:0] cl_op[3];
    logic [7:0] cl_d[3];
    logic [7:0] cl_e[3];
    cl_op = '{OP_LEAVE, OP_WAIT_PRM, OP_GC};
    cl_d = '{8'h00, 8'h00, 8'h02};
    cl_e = '{8'h0E, 8'h0F, 8'h0D};
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    seed = 32'h0000004B;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    seed = xs(seed);
    op(OP_CELL_WR, 8'h80, seed[7:0]);
    rd_cell(8'h80, seed[7:0]);
    for (int i = 0; i < 8; i++) begin
      fb[i] = 8'h00;
      op(OP_CELL_WR, 8'h80 + i[7:0], fb[i]);
    end
    check_u();
    rd_cell(ADDR_OUT_STATE, 8'h27);
    rd_cell(ADDR_DIAG_STATE, 8'h09);
    rd_cell(ADDR_OUT_FETCH, 8'h0D);
    rd_cell(ADDR_OUT_STATE, 8'h93);
    rd_cell(ADDR_OUT_FETCH, 8'h09);
    $display("test reset and fetch done");
    send_frame();
    rd_cell(ADDR_OUT_STATE, 8'h1E);
    op(OP_CELL_WR, 8'hC7, 8'h00);
    fb[7] = 8'h00;
    rd_cell(8'hC7, 8'h00);
    rd_cell(ADDR_OUT_FETCH, 8'h07);
    rd_cell(ADDR_OUT_STATE, 8'h72);
    check_u();
    send_frame();
    send_frame();
    rd_cell(ADDR_OUT_FETCH, 8'h05);
    rd_cell(ADDR_OUT_STATE, 8'hD2);
    check_u();
    chk("frame interrupts", 8'h03, irqs[7:0]);
    $display("test frames done");
    for (int i = 0; i < 3; i++) begin
      op(OP_OUT_BYTE, 8'h00, 8'h5A);
      op(cl_op[i], 8'h00, cl_d[i]);
      rd_cell(ADDR_OUT_FETCH, cl_e[i]);
      rd_cell(8'h80, 8'h00);
    end
    $display("test clear events done");
    op(OP_GC, 8'h00, 8'h20);
    rd_cell(ADDR_OUT_STATE, 8'h1B);
    chk_bit("sync active", 1'b1, sync_act);
    send_frame();
    rd_cell(ADDR_OUT_STATE, 8'h1B);
    chk("frame interrupts", 8'h03, irqs[7:0]);
    op(OP_GC, 8'h00, 8'h10);
    chk_bit("sync active", 1'b0, sync_act);
    rd_cell(ADDR_OUT_STATE, 8'h1E);
    rd_cell(ADDR_OUT_FETCH, 8'h07);
    check_u();
    $display("test sync done");
    op(OP_CELL_WR, ADDR_DIAG1_HEAD, 8'h01);
    op(OP_CELL_WR, ADDR_DIAG1_LEN, 8'hFA);
    rd_cell(ADDR_DIAG1_LEN, 8'hF3);
    rd_cell(ADDR_DIAG_SWAP, 8'h02);
    rd_cell(ADDR_DIAG_STATE, 8'h06);
    chk_bit("pending", 1'b1, st[1]);
    ahb(1'b0, HOST_DIAG, 32'h00000000, st);
    chk("diag length", 8'hF3, st[15:8]);
    chk("diag head", 8'h01, st[7:0]);
    op(OP_DIAG_START, 8'h00, 8'h00);
    op(OP_DIAG_DONE, 8'h00, 8'h00);
    chk_bit("pending", 1'b0, st[1]);
    op(OP_CELL_WR, ADDR_DIAG2_HEAD, 8'h02);
    op(OP_CELL_WR, ADDR_DIAG2_LEN, 8'h10);
    rd_cell(ADDR_DIAG_SWAP, 8'h01);
    rd_cell(ADDR_DIAG_STATE, 8'h09);
    ahb(1'b0, HOST_DIAG, 32'h00000000, st);
    chk("diag length", 8'h10, st[15:8]);
    chk("diag head", 8'h02, st[7:0]);
    op(OP_DIAG_START, 8'h00, 8'h00);
    rd_cell(ADDR_DIAG_STATE, 8'h0D);
    op(OP_DIAG_DONE, 8'h00, 8'h00);
    chk_bit("pending", 1'b1, st[1]);
    $display("test diagnosis done");
    close_out();
  end
endmodule : tb_diag_and_output_buffer_manager
`default_nettype wire
